// ### logic/lassc_top.sv
// Common section joining four line adaptors to scanner and break multiplexor
// How it works
// - Each adaptor break select follows its grant.
// - Common granted when any adaptor is granted.
// - Decode control word one and two codes.
// - Bay gating splits control word operations.
// - Character transfer sets adaptor service flag.
// - Flagged adaptor at scan address requests service.
// - Transmit clock per adaptor chosen by jumper.
// - Each adaptor reports absent or offline.
// - Priority and special lines accompany service request.
// - Any data lost drives shared lost line.
// - Accepted break address drops break request.
// - Address bit zero buffer, six bits line.
`timescale 1ns/1ps
`default_nettype none
module lassc_top #(
    parameter int unsigned N_ADAPT = lassc_pkg::NUM_ADAPTORS // Adaptors in the block
) (
    input  wire logic                 core_clk,         // 100 MHz clock
    input  wire logic                 rst,              // Synchronous reset, active high
    input  wire logic [N_ADAPT-1:0]   multiplexor_grant,// Grant per adaptor, pins
    input  wire logic                 addr_accept,      // Break address accepted, pin
    input  wire logic [6:0]           scan_address,     // Scanner address, pins
    input  wire logic [11:0]          io_instr,         // Transfer instruction word, pins
    input  wire logic                 io_pulse,         // Transfer strobe, pin
    input  wire logic [2:0]           block_address,    // Block strap
    input  wire logic [N_ADAPT-1:0]   break_wanted,     // Adaptor break demands
    input  wire logic [N_ADAPT-1:0]   char_moved,       // Character moved pulses
    input  wire logic [N_ADAPT-1:0]   flag_clear,       // Service flag clears
    input  wire logic [N_ADAPT-1:0]   adaptor_online,   // Adaptor online levels
    input  wire logic [N_ADAPT-1:0]   lost_event,       // Data lost events
    input  wire logic [N_ADAPT-1:0]   ext_clk_a,        // External transmit clock A
    input  wire logic [N_ADAPT-1:0]   ext_clk_b,        // External transmit clock B
    input  wire logic [N_ADAPT-1:0]   clk_jumper,       // Jumper: 1 picks clock B
    output logic [N_ADAPT-1:0]        adaptor_break_select, // Break select per adaptor
    output logic [N_ADAPT-1:0]        break_request_flag,   // Break request per adaptor
    output logic [N_ADAPT-1:0]        character_service_flag, // Service flags
    output logic [N_ADAPT-1:0]        cw1_bay_select,   // Control word one per bay
    output logic [N_ADAPT-1:0]        cw2_bay_select,   // Control word two per bay
    output logic [N_ADAPT-1:0]        adaptor_not_here, // Absent or offline per adaptor
    output logic [N_ADAPT-1:0]        tx_clock,         // Selected transmit clock
    output logic                      any_adaptor_granted, // Common grant
    output logic                      control_word_one_select, // Code one seen
    output logic                      control_word_two_select, // Code two seen
    output logic                      scan_service_request,    // Scan service
    output logic                      priority_request_line,   // Priority request
    output logic                      special_service_line,    // Special service
    output logic                      data_lost_line,          // Shared data lost
    output logic                      buffer_is_transmit       // Scan bit zero
);
    localparam int unsigned SW = N_ADAPT + 1 + 7 + 12 + 1 + 2 * N_ADAPT;

    // ==========================================================
    // Two-stage synchronisers for every pin input
    wire logic [SW-1:0] pin_raw = {multiplexor_grant, addr_accept, scan_address,
                                   io_instr, io_pulse, ext_clk_a, ext_clk_b};
    logic [SW-1:0] sync1_r;
    logic [SW-1:0] sync2_r;

    // First stage samples the pins; it may go metastable, so only stage two is read
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sync1_r <= '0;
        end else begin
            sync1_r <= pin_raw;
        end
    end

    // Second stage gives the settled copy that all logic uses
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sync2_r <= '0;
        end else begin
            sync2_r <= sync1_r;
        end
    end

    // Named slices of the settled pin word
    wire logic [N_ADAPT-1:0] grant_s  = sync2_r[SW-1 -: N_ADAPT];
    wire logic               accept_s = sync2_r[SW-1-N_ADAPT];
    wire logic [6:0]         scan_s   = sync2_r[SW-2-N_ADAPT -: 7];
    wire logic [11:0]        instr_s  = sync2_r[SW-9-N_ADAPT -: 12];
    wire logic               pulse_s  = sync2_r[2*N_ADAPT];
    wire logic [N_ADAPT-1:0] clka_s   = sync2_r[2*N_ADAPT-1 -: N_ADAPT];
    wire logic [N_ADAPT-1:0] clkb_s   = sync2_r[N_ADAPT-1:0];

    // ==========================================================
    // Device code decoding, used for both control words
    function automatic logic code_hit(input logic [11:0] w, input logic [5:0] code);
        code_hit = (w[11:9] == lassc_pkg::IOT_OPCODE[2:0]) &&
                   (w[lassc_pkg::DEV_CODE_MSB:lassc_pkg::DEV_CODE_LSB] == code);
    endfunction
    wire logic cw1_nxt = pulse_s && code_hit(instr_s, lassc_pkg::CTRL_WORD_ONE_CODE);
    wire logic cw2_nxt = pulse_s && code_hit(instr_s, lassc_pkg::CTRL_WORD_TWO_CODE);

    // ==========================================================
    // Bays, one per adaptor
    wire logic [N_ADAPT-1:0] bsel_w;
    wire logic [N_ADAPT-1:0] brq_w;
    wire logic [N_ADAPT-1:0] svc_w;
    wire logic [N_ADAPT-1:0] hit_w;
    wire logic [N_ADAPT-1:0] c1_w;
    wire logic [N_ADAPT-1:0] c2_w;
    wire logic [N_ADAPT-1:0] nh_w;
    wire logic [N_ADAPT-1:0] lost_w;
    genvar g;
    generate
        for (g = 0; g < N_ADAPT; g++) begin : g_bay
            lassc_bay #(.LINE_ADDR(3'(g))) u_bay (
                .core_clk               (core_clk),
                .rst                    (rst),
                .block_addr             (block_address),
                .scan_addr              (scan_s),
                .grant                  (grant_s[g]),
                .addr_accepted          (accept_s),
                .break_wanted           (break_wanted[g]),
                .char_moved             (char_moved[g]),
                .flag_clear             (flag_clear[g]),
                .cw1_sel                (cw1_nxt),
                .cw2_sel                (cw2_nxt),
                .online                 (adaptor_online[g]),
                .lost_event             (lost_event[g]),
                .break_select           (bsel_w[g]),
                .break_request_flag     (brq_w[g]),
                .character_service_flag (svc_w[g]),
                .scan_hit               (hit_w[g]),
                .bay_cw1                (c1_w[g]),
                .bay_cw2                (c2_w[g]),
                .not_here               (nh_w[g]),
                .data_lost              (lost_w[g])
            );
        end
    endgenerate

    // ==========================================================
    // Transmit clock: a jumper per adaptor picks its external source
    // Sampled, not a true clock: good only for rates well below core_clk
    wire logic [N_ADAPT-1:0] txclk_nxt;
    generate
        for (g = 0; g < N_ADAPT; g++) begin : g_txclk
            assign txclk_nxt[g] = clk_jumper[g] ? clkb_s[g] : clka_s[g];
        end
    endgenerate

    // ==========================================================
    // Common combining across the bays
    wire logic any_grant_nxt = |grant_s;
    wire logic svc_nxt       = |hit_w;
    wire logic lost_nxt      = |lost_w;
    wire logic buf_tx_nxt    = (scan_s[lassc_pkg::SCAN_BUF_BIT]
                                == lassc_pkg::BUF_TRANSMIT);

    // ==========================================================
    // Break outputs to the multiplexor
    always_ff @(posedge core_clk) begin
        if (rst) begin
            adaptor_break_select    <= '0;
            break_request_flag      <= '0;
            any_adaptor_granted     <= 1'b0;
        end else begin
            adaptor_break_select    <= bsel_w;
            break_request_flag      <= brq_w;
            any_adaptor_granted     <= any_grant_nxt;
        end
    end

    // ==========================================================
    // Control word selects, common and per bay
    always_ff @(posedge core_clk) begin
        if (rst) begin
            control_word_one_select <= 1'b0;
            control_word_two_select <= 1'b0;
            cw1_bay_select          <= '0;
            cw2_bay_select          <= '0;
        end else begin
            control_word_one_select <= cw1_nxt;
            control_word_two_select <= cw2_nxt;
            cw1_bay_select          <= c1_w;
            cw2_bay_select          <= c2_w;
        end
    end

    // ==========================================================
    // Service lines to the scanner
    // All three come from one term so the scanner never sees them apart;
    // the scanner itself turns the request into the host interrupt
    always_ff @(posedge core_clk) begin
        if (rst) begin
            character_service_flag  <= '0;
            scan_service_request    <= 1'b0;
            priority_request_line   <= 1'b0;
            special_service_line    <= 1'b0;
        end else begin
            character_service_flag  <= svc_w;
            scan_service_request    <= svc_nxt;
            priority_request_line   <= svc_nxt;
            special_service_line    <= svc_nxt;
        end
    end

    // ==========================================================
    // Status lines: presence and lost data
    always_ff @(posedge core_clk) begin
        if (rst) begin
            adaptor_not_here        <= '0;
            data_lost_line          <= 1'b0;
        end else begin
            adaptor_not_here        <= nh_w;
            data_lost_line          <= lost_nxt;
        end
    end

    // ==========================================================
    // Transmit clock and buffer side of the scan address
    always_ff @(posedge core_clk) begin
        if (rst) begin
            tx_clock                <= '0;
            buffer_is_transmit      <= 1'b0;
        end else begin
            tx_clock                <= txclk_nxt;
            buffer_is_transmit      <= buf_tx_nxt;
        end
    end
endmodule // lassc_top
`default_nettype wire

// ### logic/lassc_pkg.sv
// Shared constants for the line adaptor scan service common block
`default_nettype none
package lassc_pkg;
    localparam int unsigned NUM_ADAPTORS   = 4;
    localparam int unsigned IOT_OP_W       = 12;
    // Device codes of the two control words (selector field of the transfer word)
    localparam logic [5:0]  CTRL_WORD_ONE_CODE = 6'h30;
    localparam logic [5:0]  CTRL_WORD_TWO_CODE = 6'h31;
    localparam int unsigned DEV_CODE_LSB   = 3;
    localparam int unsigned DEV_CODE_MSB   = 8;
    localparam logic [3:0]  IOT_OPCODE     = 4'h6;
    // Scan address layout: bit 0 buffer, bits 1..3 line, bits 4..6 block
    localparam int unsigned SCAN_ADDR_W    = 7;
    localparam int unsigned SCAN_BUF_BIT   = 0;
    localparam int unsigned SCAN_LINE_LSB  = 1;
    localparam int unsigned SCAN_LINE_MSB  = 3;
    localparam int unsigned SCAN_BLK_LSB   = 4;
    localparam int unsigned SCAN_BLK_MSB   = 6;
    localparam int unsigned NUM_LINE_PAIRS = 64;
    localparam logic        BUF_RECEIVE    = 1'b0;
    localparam logic        BUF_TRANSMIT   = 1'b1;
    // Reset values
    localparam logic        FLAG_RESET     = 1'b0;
endpackage : lassc_pkg
`default_nettype wire

// ### logic/lassc_bay.sv
// One adaptor bay: service, break and selection state for a single line adaptor
`timescale 1ns/1ps
`default_nettype none
module lassc_bay #(
    parameter logic [2:0] LINE_ADDR = 3'h0      // Line address within the block
) (
    input  wire logic        core_clk,          // System clock
    input  wire logic        rst,               // Synchronous reset, active high
    input  wire logic [2:0]  block_addr,        // Block address strap of this group
    input  wire logic [6:0]  scan_addr,         // Synchronised scanner address
    input  wire logic        grant,             // Synchronised multiplexor grant
    input  wire logic        addr_accepted,     // Break address accepted pulse
    input  wire logic        break_wanted,      // Adaptor wants a break cycle
    input  wire logic        char_moved,        // One character moved to or from memory
    input  wire logic        flag_clear,        // Software clears the service flag
    input  wire logic        cw1_sel,           // Control word one decoded
    input  wire logic        cw2_sel,           // Control word two decoded
    input  wire logic        online,            // Adaptor present and online
    input  wire logic        lost_event,        // Data lost event
    output logic             break_select,      // Adaptor break select
    output logic             break_request_flag,// Break request to multiplexor
    output logic             character_service_flag, // Service flag
    output logic             scan_hit,          // Scan address matches and flag set
    output logic             bay_cw1,           // Control word one for this adaptor
    output logic             bay_cw2,           // Control word two for this adaptor
    output logic             not_here,          // Absent or offline
    output logic             data_lost          // Data lost held
);
    // ==========================================================
    // Address match and selection gating
    wire logic addr_match = (scan_addr[lassc_pkg::SCAN_BLK_MSB:lassc_pkg::SCAN_BLK_LSB]
                              == block_addr) &&
                             (scan_addr[lassc_pkg::SCAN_LINE_MSB:lassc_pkg::SCAN_LINE_LSB]
                              == LINE_ADDR);
    assign break_select = grant;
    assign bay_cw1      = cw1_sel && addr_match;
    assign bay_cw2      = cw2_sel && addr_match;
    assign not_here     = !online;
    assign scan_hit     = character_service_flag && addr_match;

    // ==========================================================
    // Flags: a set in the same cycle as a clear wins
    always_ff @(posedge core_clk) begin
        if (rst) begin
            character_service_flag <= lassc_pkg::FLAG_RESET;
            break_request_flag     <= lassc_pkg::FLAG_RESET;
            data_lost              <= lassc_pkg::FLAG_RESET;
        end else begin
            character_service_flag <= char_moved ||
                                      (character_service_flag && !flag_clear);
            break_request_flag     <= break_wanted ||
                                      (break_request_flag && !(addr_accepted && grant));
            data_lost              <= lost_event || (data_lost && !flag_clear);
        end
    end
endmodule // lassc_bay
`default_nettype wire

// ### tb/lassc_properties.sv
// Port-level assertions for the line adaptor common section
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Checker
module lassc_properties #(
    parameter int unsigned N_ADAPT = lassc_pkg::NUM_ADAPTORS // Adaptors watched
) (
    input  wire logic               core_clk,                // Clock
    input  wire logic               rst,                     // Reset, active high
    input  wire logic [N_ADAPT-1:0] multiplexor_grant,       // Grant pins
    input  wire logic [N_ADAPT-1:0] char_moved,              // Character moved pulses
    input  wire logic [N_ADAPT-1:0] lost_event,              // Data lost events
    input  wire logic [N_ADAPT-1:0] adaptor_online,          // Online levels
    input  wire logic [N_ADAPT-1:0] adaptor_break_select,    // Break selects
    input  wire logic [N_ADAPT-1:0] character_service_flag,  // Service flags
    input  wire logic [N_ADAPT-1:0] adaptor_not_here,        // Presence
    input  wire logic [6:0]         scan_address,            // Scanner address
    input  wire logic [11:0]        io_instr,                // Transfer word
    input  wire logic [2:0]         block_address,           // Block strap
    input  wire logic               io_pulse,                // Transfer strobe
    input  wire logic               any_adaptor_granted,     // Common grant
    input  wire logic               control_word_one_select, // Code one seen
    input  wire logic               scan_service_request,    // Scan service
    input  wire logic               priority_request_line,   // Priority request
    input  wire logic               special_service_line,    // Special service
    input  wire logic               data_lost_line           // Shared data lost
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // Pins cross two sync flops and an output flop, so four steady samples must show
    sequence cw_one_seen;
        io_pulse && io_instr[11:9] == lassc_pkg::IOT_OPCODE[2:0]
            && io_instr[8:3] == lassc_pkg::CTRL_WORD_ONE_CODE;
    endsequence
    sequence line0_flagged;
        $stable(scan_address) && scan_address[6:1] == {block_address, 3'h0}
            && character_service_flag[0];
    endsequence
    a_grant_select: assert property ($stable(multiplexor_grant)[*4]
        |-> adaptor_break_select == multiplexor_grant) else $error("break select off grant");
    a_any_granted: assert property ($stable(multiplexor_grant)[*4]
        |-> any_adaptor_granted == |multiplexor_grant) else $error("common grant wrong");
    a_word_one: assert property (cw_one_seen |-> ##3 control_word_one_select)
        else $error("control word one missed");
    a_char_flag: assert property (char_moved[0] |-> ##[1:3] character_service_flag[0])
        else $error("service flag not set");
    a_scan_service: assert property (line0_flagged[*4] |-> scan_service_request)
        else $error("scan service missing");
    a_service_lines: assert property (scan_service_request |-> priority_request_line
        && special_service_line) else $error("priority or special line missing");
    a_lost_line: assert property (lost_event != 0 |-> ##[1:3] data_lost_line)
        else $error("data lost line missing");
    a_not_here: assert property ($stable(adaptor_online)[*4]
        |-> adaptor_not_here == ~adaptor_online) else $error("presence wrong");
endmodule // lassc_properties
bind lassc_top lassc_properties #(.N_ADAPT(N_ADAPT)) u_lassc_properties (
    .core_clk, .rst, .multiplexor_grant, .char_moved, .lost_event, .adaptor_online,
    .adaptor_break_select, .character_service_flag, .adaptor_not_here, .scan_address,
    .io_instr, .block_address, .io_pulse, .any_adaptor_granted, .control_word_one_select,
    .scan_service_request, .priority_request_line, .special_service_line, .data_lost_line);
`default_nettype wire

// ### tb/lassc_far_end.sv
// Behavioural scanner and break multiplexor facing the common section
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Far end model
module lassc_far_end (
    input  wire logic       core_clk,             // Clock
    input  wire logic       rst,                  // Reset
    input  wire logic       slow,                 // Late grants
    input  wire logic [3:0] break_request_flag,   // Adaptor requests
    input  wire logic       scan_service_request, // Scan service
    output logic      [3:0] multiplexor_grant,    // Grant per adaptor
    output logic            addr_accept,          // Address accepted
    output logic      [6:0] scan_address          // Scanner position
);
    logic [9:0] scan_r;
    int         wait_r;
    assign scan_address = scan_r[9:3];
    // One grant at a time, held a while after the request drops so a late drop shows
    always_ff @(posedge core_clk) begin
        if (rst) begin
            {multiplexor_grant, addr_accept, scan_r, wait_r} <= '0;
        end else begin
            if (!scan_service_request) scan_r <= scan_r + 10'h1; // Parks on a request
            wait_r <= wait_r + 1;
            if (multiplexor_grant == 4'h0 && break_request_flag == 4'h0) wait_r <= 0;
            if (multiplexor_grant == 4'h0 && wait_r > (slow ? 6 : 1)) begin
                multiplexor_grant <= break_request_flag & -break_request_flag;
                wait_r <= 0;
            end
            if (multiplexor_grant != 4'h0) addr_accept <= 1'b1;
            if ((multiplexor_grant & break_request_flag) != 4'h0) wait_r <= 0;
            if (multiplexor_grant != 4'h0 && wait_r > 8) {multiplexor_grant, addr_accept} <= '0;
        end
    end
endmodule // lassc_far_end
`default_nettype wire

// ### tb/line_adaptor_scan_service_common_tb_top.sv
// Self-checking bench for the line adaptor common section
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Bench
module line_adaptor_scan_service_common_tb_top;
    logic core_clk = 1'b0, rst = 1'b1, io_pulse = 1'b0, slow = 1'b0, addr_accept;
    logic [3:0] break_wanted = '0, char_moved = '0, flag_clear = '0, lost_event = '0;
    logic [3:0] adaptor_online = '0, ext_clk_a = '0, ext_clk_b = '0, clk_jumper = '0;
    logic [3:0] multiplexor_grant, adaptor_break_select, break_request_flag, tx_clock;
    logic [3:0] character_service_flag, cw1_bay_select, cw2_bay_select, adaptor_not_here;
    logic [6:0] scan_address;
    logic [11:0] io_instr = '0;
    logic [2:0] block_address = '0;
    logic any_adaptor_granted, control_word_one_select, control_word_two_select;
    logic scan_service_request, priority_request_line, special_service_line;
    logic data_lost_line, buffer_is_transmit;
    int mismatches = 0, compares = 0, n;
    lassc_top u_lassc_top (.core_clk, .rst, .multiplexor_grant, .addr_accept, .scan_address,
        .io_instr, .io_pulse, .block_address, .break_wanted, .char_moved, .flag_clear,
        .adaptor_online, .lost_event, .ext_clk_a, .ext_clk_b, .clk_jumper, .adaptor_break_select,
        .break_request_flag, .character_service_flag, .cw1_bay_select, .cw2_bay_select,
        .adaptor_not_here, .tx_clock, .any_adaptor_granted, .control_word_one_select,
        .control_word_two_select, .scan_service_request, .priority_request_line,
        .special_service_line, .data_lost_line, .buffer_is_transmit);
    lassc_far_end u_lassc_far_end (.core_clk, .rst, .slow, .break_request_flag,
        .scan_service_request, .multiplexor_grant, .addr_accept, .scan_address);
    // Expected-value helpers
    function automatic logic [3:0] onehot(int i); return 4'h1 << i; endfunction
    function automatic logic [3:0] pick(logic [3:0] a, b, j); return (j & b) | (~j & a); endfunction
    task automatic cyc(int k); repeat (k) @(negedge core_clk); endtask
    task automatic chk(string what, logic [11:0] seen, logic [11:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("Compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial forever #5 core_clk = ~core_clk;
    // Watchdog: a full scanner sweep per adaptor is 1024 cycles
    initial begin
        cyc(20000);
        mismatches++;
        close_out();
    end
    // Per adaptor: break, service, control words, lost data, presence, clocks
    initial begin
        n = $urandom(1);
        block_address = 3'($urandom);
        cyc(10);
        rst = 1'b0;
        cyc(3);
        for (int i = 0; i < 4; i++) begin
            slow = 1'($urandom);
            break_wanted[i] = 1'b1;
            cyc(1);
            break_wanted[i] = 1'b0;
            for (n = 0; adaptor_break_select[i] !== 1'b1 && n < 60; n++) cyc(1);
            chk("break select", 12'(adaptor_break_select), 12'(onehot(i)));
            chk("any granted", 12'(any_adaptor_granted), 12'h1);
            cyc(6);
            chk("break request", 12'(break_request_flag), 12'h0);
            char_moved[i] = 1'b1;
            cyc(1);
            char_moved[i] = 1'b0;
            cyc(2);
            chk("service flag", 12'(character_service_flag), 12'(onehot(i)));
            for (n = 0; n < 3000 && !(scan_service_request === 1'b1
                && scan_address[6:1] === {block_address, 3'(i)}); n++) cyc(1);
            cyc(4);
            chk("scan service", 12'({scan_service_request, priority_request_line,
                special_service_line}), 12'h7);
            chk("buffer bit", 12'(buffer_is_transmit), 12'(scan_address[0]));
            io_instr = {3'h6, i[0] ? lassc_pkg::CTRL_WORD_TWO_CODE
                : lassc_pkg::CTRL_WORD_ONE_CODE, 3'($urandom)};
            io_pulse = 1'b1;
            cyc(4);
            chk("word select", 12'({control_word_one_select, control_word_two_select}),
                i[0] ? 12'h1 : 12'h2);
            chk("bay select", 12'({cw1_bay_select, cw2_bay_select}),
                i[0] ? 12'(onehot(i)) : 12'({onehot(i), 4'h0}));
            io_pulse = 1'b0;
            lost_event[i] = 1'b1;
            cyc(1);
            lost_event[i] = 1'b0;
            cyc(2);
            chk("lost line", 12'(data_lost_line), 12'h1);
            flag_clear[i] = 1'b1;
            cyc(1);
            flag_clear[i] = 1'b0;
            cyc(2);
            chk("cleared", 12'({scan_service_request, data_lost_line, character_service_flag}),
                12'h0);
            {adaptor_online, clk_jumper, ext_clk_a, ext_clk_b} = 16'($urandom);
            cyc(4);
            chk("not here", 12'(adaptor_not_here), {8'h00, ~adaptor_online});
            chk("tx clock", 12'(tx_clock), 12'(pick(ext_clk_a, ext_clk_b, clk_jumper)));
        end
        close_out();
    end
endmodule // line_adaptor_scan_service_common_tb_top
`default_nettype wire
